// [common/iasq_params.svh]
// Constants of the interrupt acceptance sequencer
// Contract
// - A pending request stays latched until accepted or cleared by reset or software.
// - Acceptance takes eight clocks after the current instruction completes.
// - Servicing ends when the return-from-interrupt instruction executes.
// - First acceptance step clears the master enable.
// - Accepting a non-maskable interrupt blocks all further acceptance for a while.
// - Acceptance clears the request flag of the accepted source.
// - Acceptance pushes return address and status word, three stack decrements.
// - Entry address is fetched from the vector table and loaded into the counter.
// - With master enable zero no maskable request is accepted, whatever its priority.
// - Nested requests after re-enable come only from individually enabled sources.
// - Only program counter and status word are saved by hardware.
// - The software break is an interrupt of lowest priority.
// - Break shares table call zero vector and sets the break flag.
// - Simultaneous requests of different priority: higher priority served first.
// - Ties are resolved by a fixed hardware polling order.
// - Both external inputs are edge triggered, edge chosen by register 0xf8.
// - Edges latch every machine cycle and are polled four cycles later; external flags are polled only once age_q has counted to 4.
// - An active enabled request makes the next instruction a hardware call.
// - At least twelve machine cycles from external request to first handler instruction.
// - Priorities ext0, ext1, timer0, timer1, converter, watchdog, interval, serial.
// - Disabled sources are never accepted; master enable blocks all maskable ones.
`ifndef IASQ_PARAMS_SVH
`define IASQ_PARAMS_SVH
`define IASQ_ADDR_EDGE_SEL 8'hf8
`define IASQ_ADDR_ENABLE 8'hf0
`define IASQ_ADDR_REQUEST 8'hf1
`define IASQ_ADDR_CTRL 8'hf2
`define IASQ_CTRL_IME 0
`define IASQ_CTRL_BUSY 1
`define IASQ_CTRL_BLOCK 2
`define IASQ_PSW_IME 2
`define IASQ_PSW_BRK 4
`define IASQ_EDGE_FALL 2'h1
`define IASQ_EDGE_RISE 2'h2
`define IASQ_EDGE_BOTH 2'h3
`define IASQ_ACK_CYC 8
`define IASQ_RESP_CYC 12
`define IASQ_AGE_MIN 4'h4
`define IASQ_VEC_BASE 16'hffe0
`define IASQ_VEC_TCALL0 16'hffde
`endif

// [common/iasq_pkg.sv]
// Types of the interrupt acceptance sequencer
package iasq_pkg;
	typedef enum logic [3:0] {
		IASQ_IDLE = 4'h0,
		IASQ_ACLR = 4'h1,
		IASQ_APCH = 4'h2,
		IASQ_APCL = 4'h3,
		IASQ_APSW = 4'h4,
		IASQ_AVLO = 4'h5,
		IASQ_AVHI = 4'h6,
		IASQ_AGAP = 4'h7,
		IASQ_ALOAD = 4'h8,
		IASQ_RPSW = 4'h9,
		IASQ_RPCL = 4'ha,
		IASQ_RPCH = 4'hb,
		IASQ_RLOAD = 4'hc
	} iasq_state_e;
endpackage : iasq_pkg

// [design/iasq_top.sv]
// Interrupt acceptance sequencer: latching, priority, stack and vector sequencing
`timescale 1ns/1ps
`include "iasq_params.svh"
module iasq_top #(
	parameter int NSRC = 8,
	parameter logic [15:0] VEC_BASE = `IASQ_VEC_BASE,
	parameter logic [15:0] VEC_TCALL0 = `IASQ_VEC_TCALL0
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [1:0] ext_irq_pin_i,
	input wire logic [1:0] port_zero_function_select_i,
	input wire logic [5:0] periph_irq_i,
	input wire logic instr_done_i,
	input wire logic software_break_i,
	input wire logic return_from_interrupt_i,
	input wire logic enable_irq_instruction_i,
	input wire logic [15:0] pc_i,
	input wire logic [7:0] psw_i,
	output logic busy_o,
	output logic master_en_o,
	output logic stk_push_o,
	output logic stk_pop_o,
	output logic [7:0] stk_wdata_o,
	input wire logic [7:0] stk_rdata_i,
	output logic vec_rd_o,
	output logic [15:0] vec_addr_o,
	input wire logic [7:0] vec_rdata_i,
	output logic pc_load_o,
	output logic [15:0] pc_o,
	output logic psw_load_o,
	output logic [7:0] psw_o
);
	iasq_pkg::iasq_state_e state_q;
	logic [7:0] edge_sel_q;
	logic [NSRC-1:0] en_q;
	logic [NSRC-1:0] req_q;
	logic [NSRC-1:0] req_set;
	logic [NSRC-1:0] elig;
	logic [1:0] age_ok;
	logic ime_q;
	logic block_q;
	logic brk_pend_q;
	logic is_brk_q;
	logic [2:0] src_q;
	logic [2:0] pick;
	logic pick_vld;
	logic start_acc;
	logic start_ret;
	logic [15:0] ret_pc_q;
	logic [7:0] ret_psw_q;
	logic [7:0] vec_lo_q;

	function automatic logic [2:0] first_set(input logic [NSRC-1:0] v);
		logic [2:0] r;
		r = 3'h0;
		for (int i = NSRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction : first_set

	// External pins: synchroniser, edge select, response-age counter
	for (genvar g = 0; g < 2; g++) begin : g_ext
		logic s1_q;
		logic s2_q;
		logic s3_q;
		logic [3:0] age_q;
		logic [1:0] mode;
		logic hit;
		assign mode = edge_sel_q[2*g +: 2];
		assign hit = port_zero_function_select_i[g] &&
			(((mode == `IASQ_EDGE_RISE || mode == `IASQ_EDGE_BOTH) && s2_q && !s3_q) ||
			((mode == `IASQ_EDGE_FALL || mode == `IASQ_EDGE_BOTH) && !s2_q && s3_q));
		always_ff @(posedge clk_i) begin
			if (!rst_n_i) begin
				s1_q <= 1'b0;
				s2_q <= 1'b0;
				s3_q <= 1'b0;
			end else begin
				s1_q <= ext_irq_pin_i[g];
				s2_q <= s1_q;
				s3_q <= s2_q;
			end
		end
		// Hold off polling so the handler starts no sooner than the response bound
		always_ff @(posedge clk_i) begin
			if (!rst_n_i || !req_q[g]) begin
				age_q <= 4'h0;
			end else if (age_q != `IASQ_AGE_MIN) begin
				age_q <= age_q + 4'h1;
			end
		end
		assign req_set[g] = hit;
		assign age_ok[g] = (age_q == `IASQ_AGE_MIN);
	end
	assign req_set[NSRC-1:2] = periph_irq_i;

	assign elig = req_q & en_q & {{(NSRC-2){1'b1}}, age_ok} & {NSRC{ime_q}};
	assign pick = first_set(elig);
	assign pick_vld = |elig;
	assign start_acc = (state_q == iasq_pkg::IASQ_IDLE) && instr_done_i && !block_q &&
		(pick_vld || brk_pend_q);
	assign start_ret = (state_q == iasq_pkg::IASQ_IDLE) && !start_acc && return_from_interrupt_i;

	// Acceptance and return sequence
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state_q <= iasq_pkg::IASQ_IDLE;
		end else begin
			unique case (state_q)
				iasq_pkg::IASQ_IDLE: begin
					if (start_acc) begin
						state_q <= iasq_pkg::IASQ_ACLR;
					end else if (start_ret) begin
						state_q <= iasq_pkg::IASQ_RPSW;
					end
				end
				iasq_pkg::IASQ_ACLR: state_q <= iasq_pkg::IASQ_APCH;
				iasq_pkg::IASQ_APCH: state_q <= iasq_pkg::IASQ_APCL;
				iasq_pkg::IASQ_APCL: state_q <= iasq_pkg::IASQ_APSW;
				iasq_pkg::IASQ_APSW: state_q <= iasq_pkg::IASQ_AVLO;
				iasq_pkg::IASQ_AVLO: state_q <= iasq_pkg::IASQ_AVHI;
				iasq_pkg::IASQ_AVHI: state_q <= iasq_pkg::IASQ_AGAP;
				iasq_pkg::IASQ_AGAP: state_q <= iasq_pkg::IASQ_ALOAD;
				iasq_pkg::IASQ_ALOAD: state_q <= iasq_pkg::IASQ_IDLE;
				iasq_pkg::IASQ_RPSW: state_q <= iasq_pkg::IASQ_RPCL;
				iasq_pkg::IASQ_RPCL: state_q <= iasq_pkg::IASQ_RPCH;
				iasq_pkg::IASQ_RPCH: state_q <= iasq_pkg::IASQ_RLOAD;
				iasq_pkg::IASQ_RLOAD: state_q <= iasq_pkg::IASQ_IDLE;
				default: state_q <= iasq_pkg::IASQ_IDLE;
			endcase
		end
	end

	// Source capture at acceptance start
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			src_q <= 3'h0;
			is_brk_q <= 1'b0;
		end else if (start_acc) begin
			src_q <= pick;
			is_brk_q <= !pick_vld;
		end
	end

	// Request flags: hardware set wins over any clear
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			req_q <= '0;
		end else begin
			for (int i = 0; i < NSRC; i++) begin
				if (req_set[i]) begin
					req_q[i] <= 1'b1;
				end else if (state_q == iasq_pkg::IASQ_ACLR && !is_brk_q && src_q == 3'(i)) begin
					req_q[i] <= 1'b0;
				end else if (wr_i && addr_i == `IASQ_ADDR_REQUEST && !wdata_i[i]) begin
					req_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			brk_pend_q <= 1'b0;
		end else if (software_break_i) begin
			brk_pend_q <= 1'b1;
		end else if (start_acc && !pick_vld) begin
			brk_pend_q <= 1'b0;
		end
	end

	// Master enable
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ime_q <= 1'b0;
		end else if (state_q == iasq_pkg::IASQ_ACLR) begin
			ime_q <= 1'b0;
		end else if (state_q == iasq_pkg::IASQ_RLOAD) begin
			ime_q <= ret_psw_q[`IASQ_PSW_IME];
		end else if (enable_irq_instruction_i) begin
			ime_q <= 1'b1;
		end else if (wr_i && addr_i == `IASQ_ADDR_CTRL) begin
			ime_q <= wdata_i[`IASQ_CTRL_IME];
		end
	end

	// Non-maskable break blocks every acceptance until its return
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			block_q <= 1'b0;
		end else if (state_q == iasq_pkg::IASQ_ACLR && is_brk_q) begin
			block_q <= 1'b1;
		end else if (state_q == iasq_pkg::IASQ_RLOAD) begin
			block_q <= 1'b0;
		end
	end

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			edge_sel_q <= 8'h00;
			en_q <= '0;
		end else if (wr_i) begin
			if (addr_i == `IASQ_ADDR_EDGE_SEL) begin
				edge_sel_q <= wdata_i;
			end
			if (addr_i == `IASQ_ADDR_ENABLE) begin
				en_q <= wdata_i[NSRC-1:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			unique case (addr_i)
				`IASQ_ADDR_EDGE_SEL: rdata_o <= edge_sel_q;
				`IASQ_ADDR_ENABLE: rdata_o <= 8'(en_q);
				`IASQ_ADDR_REQUEST: rdata_o <= 8'(req_q);
				`IASQ_ADDR_CTRL: rdata_o <= {5'h00, block_q, busy_o, ime_q};
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Stack push and pop strobes; only PC and PROGRAM_STATUS_WORD are saved
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stk_push_o <= 1'b0;
			stk_wdata_o <= 8'h00;
		end else begin
			stk_push_o <= 1'b0;
			unique case (state_q)
				iasq_pkg::IASQ_APCH: begin
					stk_push_o <= 1'b1;
					stk_wdata_o <= pc_i[15:8];
				end
				iasq_pkg::IASQ_APCL: begin
					stk_push_o <= 1'b1;
					stk_wdata_o <= pc_i[7:0];
				end
				iasq_pkg::IASQ_APSW: begin
					stk_push_o <= 1'b1;
					stk_wdata_o <= {psw_i[7:5], is_brk_q, psw_i[3], 1'b1, psw_i[1:0]};
				end
				default: stk_wdata_o <= stk_wdata_o;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			stk_pop_o <= 1'b0;
		end else begin
			stk_pop_o <= start_ret || state_q == iasq_pkg::IASQ_RPSW ||
				state_q == iasq_pkg::IASQ_RPCL;
		end
	end

	// Pop data arrive the cycle after each pop strobe
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ret_psw_q <= 8'h00;
			ret_pc_q <= 16'h0000;
		end else begin
			if (state_q == iasq_pkg::IASQ_RPCL) begin
				ret_psw_q <= stk_rdata_i;
			end
			if (state_q == iasq_pkg::IASQ_RPCH) begin
				ret_pc_q[7:0] <= stk_rdata_i;
			end
			if (state_q == iasq_pkg::IASQ_RLOAD) begin
				ret_pc_q[15:8] <= stk_rdata_i;
			end
		end
	end

	// Vector fetch
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			vec_rd_o <= 1'b0;
			vec_addr_o <= 16'h0000;
			vec_lo_q <= 8'h00;
		end else begin
			vec_rd_o <= state_q == iasq_pkg::IASQ_APSW || state_q == iasq_pkg::IASQ_AVLO;
			if (state_q == iasq_pkg::IASQ_APSW) begin
				vec_addr_o <= is_brk_q ? VEC_TCALL0 : VEC_BASE + {12'h000, src_q, 1'b0};
			end else if (state_q == iasq_pkg::IASQ_AVLO) begin
				vec_addr_o <= vec_addr_o + 16'h0001;
			end
			if (state_q == iasq_pkg::IASQ_AVHI) begin
				vec_lo_q <= vec_rdata_i;
			end
		end
	end

	// Program counter and status word loads
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			pc_load_o <= 1'b0;
			pc_o <= 16'h0000;
			psw_load_o <= 1'b0;
			psw_o <= 8'h00;
		end else begin
			pc_load_o <= 1'b0;
			psw_load_o <= 1'b0;
			if (state_q == iasq_pkg::IASQ_AGAP) begin
				pc_o <= {vec_rdata_i, vec_lo_q};
			end else if (state_q == iasq_pkg::IASQ_ALOAD) begin
				pc_load_o <= 1'b1;
				psw_load_o <= 1'b1;
				psw_o <= {psw_i[7:5], is_brk_q, psw_i[3], 1'b0, psw_i[1:0]};
			end else if (state_q == iasq_pkg::IASQ_RLOAD) begin
				pc_load_o <= 1'b1;
				psw_load_o <= 1'b1;
				pc_o <= {stk_rdata_i, ret_pc_q[7:0]};
				psw_o <= ret_psw_q;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
			master_en_o <= 1'b0;
		end else begin
			busy_o <= start_acc || start_ret ||
				(state_q != iasq_pkg::IASQ_IDLE && state_q != iasq_pkg::IASQ_ALOAD &&
				state_q != iasq_pkg::IASQ_RLOAD);
			master_en_o <= ime_q;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	chk_ack_eight: assert property (start_acc |-> ##8 state_q == iasq_pkg::IASQ_ALOAD ##1 pc_load_o)
		else $error("acceptance did not load pc after eight clocks");
	chk_ime_clear: assert property (state_q == iasq_pkg::IASQ_ACLR |=> !ime_q)
		else $error("master enable not cleared at acceptance");
	chk_three_push: assert property (start_acc |-> ##3 stk_push_o [*3] ##1 !stk_push_o)
		else $error("acceptance did not push three bytes");
	chk_masked_none: assert property (!ime_q && !brk_pend_q |-> !start_acc)
		else $error("accepted while master enable clear");
	chk_flag_clear: assert property (state_q == iasq_pkg::IASQ_ACLR && !is_brk_q && !req_set[src_q]
		|=> !req_q[$past(src_q)])
		else $error("accepted flag not cleared");
	chk_flag_hold: assert property (req_q[2] && state_q != iasq_pkg::IASQ_ACLR &&
		!(wr_i && addr_i == `IASQ_ADDR_REQUEST) |=> req_q[2])
		else $error("pending flag lost");
	chk_brk_lowest: assert property (start_acc && pick_vld |=> !is_brk_q)
		else $error("break taken over a maskable request");
	chk_prio_order: assert property (start_acc && elig[0] |=> src_q == 3'h0)
		else $error("higher priority source not chosen");
	chk_brk_block: assert property (state_q == iasq_pkg::IASQ_ACLR && is_brk_q |=> block_q && !start_acc)
		else $error("no block after break acceptance");
	chk_ret_three: assert property (start_ret |=> stk_pop_o [*3] ##1 !stk_pop_o ##1 pc_load_o)
		else $error("return did not pop three bytes");
	cov_ext_accept: cover property (req_q[0] ##[1:20] start_acc && pick == 3'h0);
	cov_break: cover property (start_acc && !pick_vld);
	cov_return: cover property (start_ret ##5 pc_load_o);
endmodule : iasq_top

// [tb/iasq_core_model.sv]
// Behavioural core side of the sequencer: stack memory and vector table
`timescale 1ns/1ps
module iasq_core_model (
	input wire logic clk_i,
	input wire logic stk_push_i,
	input wire logic stk_pop_i,
	input wire logic [7:0] stk_wdata_i,
	output logic [7:0] stk_rdata_o,
	input wire logic vec_rd_i,
	input wire logic [15:0] vec_addr_i,
	output logic [7:0] vec_rdata_o,
	output logic [7:0] sp_o
);
	logic [7:0] mem [256];
	initial begin
		sp_o = 8'hff;
		stk_rdata_o = 8'h00;
		vec_rdata_o = 8'h00;
	end
	// Data lines carry a valid byte only in the answer cycle and toggle otherwise
	always @(posedge clk_i) begin
		if (stk_push_i) begin
			mem[sp_o] <= stk_wdata_i;
			sp_o <= sp_o - 8'h01;
		end
		if (stk_pop_i) begin
			stk_rdata_o <= mem[sp_o + 8'h01];
			sp_o <= sp_o + 8'h01;
		end else begin
			stk_rdata_o <= ~stk_rdata_o;
		end
		vec_rdata_o <= vec_rd_i ? (vec_addr_i[7:0] ^ 8'h5a) : ~vec_rdata_o;
	end
endmodule : iasq_core_model

// [tb/iasq_top_tb.sv]
// Self-checking bench of the interrupt acceptance sequencer
`timescale 1ns/1ps
`include "iasq_params.svh"
module iasq_top_tb;
	logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic idone = 1'b0, software_break = 1'b0, return_from_interrupt = 1'b0, ei = 1'b0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, esp = 8'hff;
	logic [7:0] rdata_o, stk_wdata_o, stk_rdata, vec_rdata, psw_o, sp;
	logic [1:0] pin = 2'h0, fsel = 2'h0;
	logic [5:0] pirq = 6'h00;
	logic [15:0] vec_addr_o, pc_o;
	logic master_en_o, stk_push_o, stk_pop_o, vec_rd_o, pc_load_o, busy_o, psw_load_o;
	int mismatches = 0, cmp_count = 0, cyc = 0, k = 0;
	always #50 clk_i = ~clk_i;
	iasq_top u_dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.ext_irq_pin_i(pin), .port_zero_function_select_i(fsel), .periph_irq_i(pirq),
		.instr_done_i(idone), .software_break_i(software_break), .return_from_interrupt_i(return_from_interrupt),
		.enable_irq_instruction_i(ei), .pc_i(16'h1234), .psw_i(8'h01), .busy_o,
		.master_en_o, .stk_push_o, .stk_pop_o, .stk_wdata_o, .stk_rdata_i(stk_rdata),
		.vec_rd_o, .vec_addr_o, .vec_rdata_i(vec_rdata), .pc_load_o, .pc_o,
		.psw_load_o, .psw_o);
	iasq_core_model u_core (.clk_i, .stk_push_i(stk_push_o), .stk_pop_i(stk_pop_o),
		.stk_wdata_i(stk_wdata_o), .stk_rdata_o(stk_rdata), .vec_rd_i(vec_rd_o),
		.vec_addr_i(vec_addr_o), .vec_rdata_o(vec_rdata), .sp_o(sp));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			stop_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [15:0] vexp(input logic [15:0] a);
		return {(a[7:0] + 8'h01) ^ 8'h5a, a[7:0] ^ 8'h5a};
	endfunction : vexp
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 chk(16'(rdata_o), 16'(e));
	endtask : rd
	// One-cycle core events, all in the same cycle
	task automatic ev(input logic [5:0] p, input logic b, input logic e);
		@(posedge clk_i);
		pirq <= p;
		software_break <= b;
		ei <= e;
		@(posedge clk_i);
		pirq <= 6'h00;
		software_break <= 1'b0;
		ei <= 1'b0;
	endtask : ev
	task automatic wait_load(input int lim, output int n);
		n = 1;
		#1;
		while (pc_load_o !== 1'b1 && n < lim) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (pc_load_o === 1'b1) begin
			chk(16'({psw_load_o, busy_o}), 16'h0002);
		end
	endtask : wait_load
	task automatic frame(input logic b);
		esp = esp - 8'h03;
		chk(16'(sp), 16'(esp));
		chk({u_core.mem[sp + 8'h03], u_core.mem[sp + 8'h02]}, 16'h1234);
		chk(16'({u_core.mem[sp + 8'h01][4], u_core.mem[sp + 8'h01][2]}), 16'({b, 1'b1}));
		chk(16'({psw_o[4], psw_o[2], master_en_o}), 16'({b, 2'b00}));
	endtask : frame
	// Index 8 is the software break, a negative index expects no acceptance
	task automatic acc(input int idx);
		logic [15:0] va;
		int n;
		va = (idx == 8) ? 16'(`IASQ_VEC_TCALL0) : 16'(`IASQ_VEC_BASE) + 16'(2 * idx);
		@(posedge clk_i);
		idone <= 1'b1;
		@(posedge clk_i);
		idone <= 1'b0;
		#1 chk(16'(busy_o), 16'(idx >= 0));
		wait_load(12, n);
		if (idx < 0) begin
			chk(16'(n), 16'd12);
		end else begin
			// Count runs to the registered load strobe, one clock after the last sequence step
			chk(16'(n), 16'(`IASQ_ACK_CYC + 1));
			chk(pc_o, vexp(va));
			frame(idx == 8);
		end
	endtask : acc
	task automatic ret();
		int n;
		@(posedge clk_i);
		return_from_interrupt <= 1'b1;
		@(posedge clk_i);
		return_from_interrupt <= 1'b0;
		wait_load(12, n);
		chk(16'(n), 16'd5);
		esp = esp + 8'h03;
		chk(16'(sp), 16'(esp));
		chk(pc_o, 16'h1234);
		repeat (2) @(posedge clk_i);
		#1 chk(16'(master_en_o), 16'h0001);
	endtask : ret
	initial begin
		repeat (8) @(posedge clk_i);
		rst_n_i <= 1'b1;
		fsel <= 2'h3;
		rd(8'hf8, 8'h00);
		rd(8'hf2, 8'h00);
		rd(8'h10, 8'h00);
		// Masked request waits, then is taken once enabled
		wr(8'hf0, 8'h04);
		ev(6'h01, 1'b0, 1'b0);
		acc(-1);
		rd(8'hf1, 8'h04);
		ev(6'h00, 1'b0, 1'b1);
		acc(2);
		rd(8'hf1, 8'h00);
		// Nesting inside the handler
		ev(6'h20, 1'b0, 1'b1);
		acc(-1);
		ev(6'h01, 1'b0, 1'b0);
		acc(2);
		ret();
		ret();
		// Simultaneous requests of different priority
		wr(8'hf0, 8'h48);
		ev(6'h12, 1'b0, 1'b0);
		acc(3);
		ret();
		acc(6);
		ret();
		acc(-1);
		rd(8'hf1, 8'h80);
		// Break loses to a maskable source and blocks everything while served
		wr(8'hf0, 8'h04);
		ev(6'h01, 1'b1, 1'b0);
		acc(2);
		ret();
		acc(8);
		ev(6'h01, 1'b0, 1'b1);
		rd(8'hf2, 8'h05);
		acc(-1);
		ret();
		acc(2);
		ret();
		// External pins: ext zero on falling edges, ext one on both
		wr(8'hf8, 8'h0d);
		wr(8'hf0, 8'h03);
		@(posedge clk_i);
		pin <= 2'h1;
		repeat (6) @(posedge clk_i);
		rd(8'hf1, 8'h80);
		@(posedge clk_i);
		pin <= 2'h0;
		idone <= 1'b1;
		wait_load(40, k);
		chk(16'(k >= 12), 16'h0001);
		chk(pc_o, vexp(16'(`IASQ_VEC_BASE)));
		frame(1'b0);
		@(posedge clk_i);
		idone <= 1'b0;
		ret();
		@(posedge clk_i);
		pin <= 2'h2;
		repeat (6) @(posedge clk_i);
		rd(8'hf1, 8'h82);
		wr(8'hf1, 8'h00);
		rd(8'hf1, 8'h00);
		// Rising-only ext zero, falling edge of ext one in both-edge mode
		wr(8'hf8, 8'h0e);
		@(posedge clk_i);
		pin <= 2'h1;
		repeat (6) @(posedge clk_i);
		rd(8'hf1, 8'h03);
		// Reset in mid-run drops pending flags and configuration
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		@(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(8'hf1, 8'h00);
		rd(8'hf8, 8'h00);
		rd(8'hf2, 8'h00);
		// Pins left on their port function raise no flag
		wr(8'hf8, 8'h0f);
		@(posedge clk_i);
		fsel <= 2'h0;
		pin <= 2'h2;
		repeat (6) @(posedge clk_i);
		rd(8'hf1, 8'h00);
		stop_test();
	end
endmodule : iasq_top_tb
